/* File: rtl/mcsw_top.sv */
`timescale 1ns/1ps
// Operation
// [R1] Service rising edge clears watchdog timer
// [R2] Watchdog expiry asserts reset output
// [R3] Watchdog expiry asserts open-drain fault flag
// [R4] Microcontroller services faster than timeout
// [R5] Eight timeouts from 16 to 2048 ms
// [R6] Two ternary straps choose the timeout
// [R7] Both straps high disable the watchdog
// [R8] Speed high full clock, low half
// [R9] Reset held while supply low
// [R10] Reset polarity and drive by build option
// [R11] Clock output never has short phases
// [R12] Reset stretched 135 us after supply recovers
// [R13] Fault holds until edge; timer restarts on release
// [R14] Watchdog timer stopped while reset asserted
// [R15] Doubling per step, first strap low digit
// [R16] Service input synchronised, edge registered once
// [R17] Speed change applied at period boundary
module mcsw_top
    import mcsw_pkg::*;
#(
    parameter int unsigned RST_MODE    = RST_PP_LOW,
    parameter int unsigned RST_CYCLES  = RST_CYC,
    parameter int unsigned WD_BASE     = WD_BASE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Microcontroller side
    input  wire logic        wd_service_in,
    input  wire logic        speed_sel,
    input  wire logic [1:0]  timeout_strap_a,
    input  wire logic [1:0]  timeout_strap_b,
    input  wire logic        supply_low,
    output logic             mcu_clk_out,
    output logic             mcu_rst_out,
    output logic             mcu_rst_oe_n,
    output logic             wd_fault_out,
    output logic             wd_fault_oe_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);

    // Ternary digit: floating (01 or 11) reads as mid-supply
    function automatic logic [1:0] strap_digit(input logic [1:0] code);
        if (code == STRAP_LOW) begin
            strap_digit = 2'h0;
        end else if (code == STRAP_HIGH) begin
            strap_digit = 2'h2;
        end else begin
            strap_digit = 2'h1;
        end
    endfunction : strap_digit

    // Shared by the read mux and the write strobes
    function automatic logic [2:0] reg_decode(input logic [7:0] addr);
        reg_decode = 3'h0;
        if (addr == OFS_STATUS) begin
            reg_decode[0] = 1'b1;
        end
        if (addr == OFS_MASK) begin
            reg_decode[1] = 1'b1;
        end
        if (addr == OFS_STATE) begin
            reg_decode[2] = 1'b1;
        end
    endfunction : reg_decode

    // Pin synchronisers
    logic [6:0] pins_s;
    mcsw_sync #(.WIDTH(7)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({supply_low, speed_sel, wd_service_in, timeout_strap_b, timeout_strap_a}),
        .sync_out (pins_s)
    );

    wire logic [1:0] strap_a_s   = pins_s[1:0];
    wire logic [1:0] strap_b_s   = pins_s[3:2];
    wire logic       service_s   = pins_s[4];
    wire logic       speed_s     = pins_s[5];
    wire logic       supply_lo_s = pins_s[6];

    // Service edge from unregistered comparison of synced level with its registered copy
    logic service_d;
    wire logic service_edge = service_s & ~service_d;                  // [R16] [R1]

    // Timeout selection
    wire logic [3:0] wd_sel = 4'(strap_digit(strap_a_s))
                            + 4'(3 * strap_digit(strap_b_s));          // [R6] [R15]
    wire logic       wd_disabled = (wd_sel == STRAP_DISABLE);          // [R7]
    wire logic [WD_CNT_W-1:0] wd_limit =
        WD_CNT_W'(WD_BASE) << wd_sel[2:0];                             // [R5] [R15]

    // Supervisor state
    mcsw_state_t              state;
    mcsw_state_t              next_state;
    logic [WD_CNT_W-1:0]      rst_cnt;
    logic [WD_CNT_W-1:0]      wd_cnt;
    logic                     wd_fault;

    wire logic rst_active  = (state != MCSW_RUN);
    wire logic rst_done    = (rst_cnt >= WD_CNT_W'(RST_CYCLES - 1));
    wire logic wd_expire   = (state == MCSW_RUN) && !wd_disabled && !service_edge
                           && (wd_cnt >= wd_limit - WD_CNT_W'(1));      // [R2] [R4]

    always_comb begin
        next_state = state;
        unique case (state)
            MCSW_SUPPLY_LOW: begin
                if (!supply_lo_s) begin
                    next_state = MCSW_STRETCH;                         // [R12]
                end
            end
            MCSW_STRETCH: begin
                if (supply_lo_s) begin
                    next_state = MCSW_SUPPLY_LOW;                      // [R9]
                end else if (rst_done) begin
                    next_state = MCSW_RUN;
                end
            end
            MCSW_RUN: begin
                if (supply_lo_s) begin
                    next_state = MCSW_SUPPLY_LOW;                      // [R9]
                end else if (wd_expire) begin
                    next_state = MCSW_STRETCH;                         // [R2]
                end
            end
            // Unused code falls back to a reset stretch
            default: begin
                next_state = MCSW_STRETCH;
            end
        endcase
    end

    // Stretch counter runs only inside the stretch state
    wire logic [WD_CNT_W-1:0] next_rst_cnt =
        (state == MCSW_STRETCH) ? rst_cnt + WD_CNT_W'(1) : '0;         // [R12]

    // Watchdog counter: frozen at zero under reset or when disabled
    wire logic [WD_CNT_W-1:0] next_wd_cnt =
        (rst_active || wd_disabled || service_edge || wd_expire) ? '0
                                                   : wd_cnt + WD_CNT_W'(1); // [R14] [R1] [R13]

    // Expiry sets the flag; only a service edge clears it
    wire logic next_wd_fault = wd_expire | (wd_fault & ~service_edge); // [R3] [R13]

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state   <= MCSW_STRETCH;
            rst_cnt <= '0;
        end else begin
            state   <= next_state;
            rst_cnt <= next_rst_cnt;
        end
    end

    // Timer held clear under reset, so each release starts a full period
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wd_cnt   <= '0;
            wd_fault <= 1'b0;
        end else begin
            wd_cnt   <= next_wd_cnt;                                   // [R14]
            wd_fault <= next_wd_fault;                                 // [R3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            service_d <= 1'b0;
        end else begin
            service_d <= service_s;                                    // [R16]
        end
    end

    // Reset and fault pins; open-drain enables are low while pulling low
    always_comb begin
        unique case (RST_MODE)
            RST_PP_HIGH: begin
                mcu_rst_out  = rst_active;                             // [R10]
                mcu_rst_oe_n = 1'b0;
            end
            RST_OD_LOW: begin
                mcu_rst_out  = 1'b0;                                   // [R10]
                mcu_rst_oe_n = ~rst_active;
            end
            default: begin
                mcu_rst_out  = ~rst_active;                            // [R10]
                mcu_rst_oe_n = 1'b0;
            end
        endcase
    end

    assign wd_fault_out  = 1'b0;
    assign wd_fault_oe_n = ~wd_fault;                                  // [R3]

    // Clock output: full rate is core_clk / 2, half rate core_clk / 4
    logic clk_q;
    logic half_phase;
    logic speed_cur;
    wire logic clk_toggle = speed_cur | half_phase;
    // Boundary is the last cycle of a low phase; only there may speed change
    wire logic period_end = ~clk_q & clk_toggle;                       // [R17] [R11]

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            clk_q      <= 1'b0;
            half_phase <= 1'b0;
            speed_cur  <= 1'b1;
        end else begin
            clk_q      <= clk_toggle ? ~clk_q : clk_q;                 // [R8]
            half_phase <= (period_end | speed_cur) ? 1'b0 : ~half_phase; // [R11]
            speed_cur  <= period_end ? speed_s : speed_cur;            // [R17]
        end
    end

    assign mcu_clk_out = clk_q;

    // Interrupt events
    logic rst_active_d;
    logic supply_lo_d;
    wire logic [EV_W-1:0] events = {
        service_edge,
        rst_active_d & ~rst_active,
        supply_lo_s & ~supply_lo_d,
        wd_expire
    };

    // AHB-Lite slave: zero wait states, always OKAY
    logic             dp_write;
    logic [7:0]       dp_addr;
    logic [EV_W-1:0]  status;
    logic [EV_W-1:0]  mask;

    wire logic       ap_valid = hsel & htrans[1] & hready;
    wire logic [7:0] ap_addr  = {haddr[7:2], 2'b00};
    wire logic [2:0] ap_hit   = reg_decode(ap_addr);
    wire logic [2:0] dp_hit   = reg_decode(dp_addr);
    wire logic       wr_stat  = dp_write & dp_hit[0];
    wire logic       wr_mask  = dp_write & dp_hit[1];

    wire logic [31:0] state_word = {
        24'h00_0000,
        wd_sel,
        wd_disabled,
        speed_cur,
        wd_fault,
        rst_active
    };

    wire logic [31:0] rd_word =
        ap_hit[0] ? 32'(status) :
        ap_hit[1] ? 32'(mask)   :
        ap_hit[2] ? state_word  : 32'h0000_0000;

    // Hardware set wins over a write-one clear in the same cycle
    wire logic [EV_W-1:0] next_status =
        (status & ~(wr_stat ? hwdata[EV_W-1:0] : '0)) | events;
    wire logic [EV_W-1:0] next_mask = wr_mask ? hwdata[EV_W-1:0] : mask;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
            hrdata   <= 32'h0000_0000;
        end else begin
            dp_write <= ap_valid & hwrite;
            dp_addr  <= ap_addr;
            hrdata   <= (ap_valid & ~hwrite) ? rd_word : hrdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            status <= STATUS_RST;
            mask   <= MASK_RST;
        end else begin
            status <= next_status;
            mask   <= next_mask;
        end
    end

    // History starts at the reset levels, so no false event after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rst_active_d <= 1'b1;
            supply_lo_d  <= 1'b0;
        end else begin
            rst_active_d <= rst_active;
            supply_lo_d  <= supply_lo_s;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(status & mask);

endmodule : mcsw_top

/* File: rtl/mcsw_pkg.sv */
package mcsw_pkg;

    // Clock
    localparam int unsigned CLK_PERIOD_NS = 5;

    // Reset stretch after supply recovery or watchdog expiry
    localparam int unsigned T_RST_NS      = 135_000;
    localparam int unsigned RST_CYC       = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Shortest watchdog period; each strap step doubles it
    localparam int unsigned T_WD_BASE_MS  = 16;
    localparam int unsigned WD_BASE_CYC   = T_WD_BASE_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned WD_STEPS      = 8;
    localparam int unsigned WD_CNT_W      = 32;

    // Three-level strap codes on two input bits
    localparam logic [1:0] STRAP_LOW      = 2'h0;
    localparam logic [1:0] STRAP_HIGH     = 2'h2;
    localparam logic [3:0] STRAP_DISABLE  = 4'h8;

    // Reset output build options
    localparam int unsigned RST_PP_HIGH   = 0;
    localparam int unsigned RST_PP_LOW    = 1;
    localparam int unsigned RST_OD_LOW    = 2;

    // Register map (byte addresses)
    localparam logic [7:0] OFS_STATUS     = 8'h00;
    localparam logic [7:0] OFS_MASK       = 8'h04;
    localparam logic [7:0] OFS_STATE      = 8'h08;

    // Status and mask bit positions
    localparam int unsigned EV_EXPIRE     = 0;
    localparam int unsigned EV_SUPPLY     = 1;
    localparam int unsigned EV_RELEASE    = 2;
    localparam int unsigned EV_SERVICE    = 3;
    localparam int unsigned EV_W          = 4;

    // State register bit positions
    localparam int unsigned ST_RST_BIT    = 0;
    localparam int unsigned ST_FAULT_BIT  = 1;
    localparam int unsigned ST_SPEED_BIT  = 2;
    localparam int unsigned ST_DIS_BIT    = 3;
    localparam int unsigned ST_SEL_LSB    = 4;

    // Reset values
    localparam logic [EV_W-1:0] STATUS_RST = 4'h0;
    localparam logic [EV_W-1:0] MASK_RST   = 4'h0;

    typedef enum logic [1:0] {
        MCSW_SUPPLY_LOW,
        MCSW_STRETCH,
        MCSW_RUN
    } mcsw_state_t;

endpackage : mcsw_pkg

/* File: rtl/mcsw_sync.sv */
`timescale 1ns/1ps
module mcsw_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : mcsw_sync

/* File: dv/mcsw_mcu_model.sv */
`timescale 1ns/1ps
module mcsw_mcu_model (
    input  wire logic       core_clk,
    input  wire logic       active,
    input  wire logic [7:0] gap,
    output logic            wd_service_in
);
    int cnt = 0;
    initial wd_service_in = 1'b0;
    // Port pin pulses high once every gap + 1 cycles, well inside the timeout
    always @(posedge core_clk) begin
        if (!active) begin
            cnt <= 0;
            wd_service_in <= 1'b0;
        end else begin
            cnt <= (cnt >= int'(gap)) ? 0 : cnt + 1;
            wd_service_in <= (cnt < int'(gap) / 2);
        end
    end
endmodule : mcsw_mcu_model

/* File: dv/mcsw_props.sv */
`timescale 1ns/1ps
module mcsw_props #(
    parameter int unsigned RST_CYCLES = 20,
    parameter int unsigned WD_BASE    = 50
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wd_service_in,
    input wire logic speed_sel,
    input wire logic supply_low,
    input wire logic mcu_clk_out,
    input wire logic mcu_rst_out,
    input wire logic wd_fault_out,
    input wire logic wd_fault_oe_n
);
    logic [31:0] asrt_cnt;
    logic [31:0] run_cnt;
    logic        svc_q;
    logic [2:0]  up;
    // Run count restarts on the raw pin edge, so it bounds the synced timer from above
    always_ff @(posedge core_clk) begin
        svc_q    <= wd_service_in;
        up       <= !rst_n ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
        asrt_cnt <= (!rst_n || mcu_rst_out) ? 32'h0 : asrt_cnt + 32'h1;
        run_cnt  <= (!rst_n || !mcu_rst_out || (wd_service_in && !svc_q)) ? 32'h0
                    : run_cnt + 32'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_supply_holds_rst: assert property (supply_low [*4] |-> !mcu_rst_out)
        else $error("reset output free while supply low");
    a_stretch_length: assert property ($rose(mcu_rst_out) |-> asrt_cnt >= RST_CYCLES - 1)
        else $error("reset released early");
    a_no_early_trip: assert property ($fell(wd_fault_oe_n) |-> run_cnt >= WD_BASE)
        else $error("watchdog tripped early");
    a_trip_asserts_rst: assert property ($fell(wd_fault_oe_n) |-> ##[0:1] !mcu_rst_out)
        else $error("expiry without reset");
    a_fault_data_low: assert property (wd_fault_out == 1'b0)
        else $error("fault pin data not low");
    a_fault_until_edge: assert property ($rose(wd_fault_oe_n) |-> run_cnt <= 4)
        else $error("fault cleared without service edge");
    a_full_rate: assert property (speed_sel [*8] ##0 (up == 3'h7 && mcu_rst_out)
        |-> mcu_clk_out != $past(mcu_clk_out))
        else $error("full rate clock wrong");
    a_half_rate: assert property ((!speed_sel) [*8] ##0 (up == 3'h7 && mcu_rst_out
        && $changed(mcu_clk_out)) |=> $stable(mcu_clk_out))
        else $error("half rate phase short");
endmodule : mcsw_props
bind mcsw_top mcsw_props #(.RST_CYCLES(RST_CYCLES), .WD_BASE(WD_BASE)) mcsw_props_i (
    .core_clk, .rst_n, .wd_service_in, .speed_sel, .supply_low, .mcu_clk_out,
    .mcu_rst_out, .wd_fault_out, .wd_fault_oe_n);

/* File: dv/tb_mcu_clock_supervisor_watchdog.sv */
`timescale 1ns/1ps
module tb_mcu_clock_supervisor_watchdog;
    import mcsw_pkg::*;
    localparam int unsigned RC = 20;
    localparam int unsigned WB = 50;
    logic core_clk = 1'b0, rst_n = 1'b0, speed_sel = 1'b1, supply_low = 1'b0, active = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, wd_service_in, b;
    logic [1:0] timeout_strap_a = 2'h0, timeout_strap_b = 2'h0, htrans = 2'h0;
    logic [7:0] gap = 8'h14;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic mcu_clk_out, mcu_rst_out, mcu_rst_oe_n, wd_fault_out, wd_fault_oe_n, hreadyout, hresp, irq;
    int err_count = 0, samples_checked = 0, n;
    logic [31:0] exp_q[$], got_q[$];
    initial forever #2.5 core_clk = ~core_clk;
    mcsw_top #(.RST_CYCLES(RC), .WD_BASE(WB)) mcsw_top_i (.core_clk, .rst_n, .wd_service_in,
        .speed_sel, .timeout_strap_a, .timeout_strap_b, .supply_low, .mcu_clk_out,
        .mcu_rst_out, .mcu_rst_oe_n, .wd_fault_out, .wd_fault_oe_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq);
    mcsw_mcu_model mcsw_mcu_model_i (.core_clk, .active, .gap, .wd_service_in);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task note(input logic [31:0] seen, input logic [31:0] exp);
        got_q.push_back(seen);
        exp_q.push_back(exp);
    endtask : note
    always @(negedge core_clk) while (exp_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    task cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
        @(posedge core_clk); while (!hreadyout) @(posedge core_clk);
        htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
        @(posedge core_clk); while (!hreadyout) @(posedge core_clk);
        rd = hrdata;
    endtask : ahb
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    function automatic logic [1:0] dig(input int d);
        return d == 2 ? STRAP_HIGH : (d == 1 ? 2'h1 : STRAP_LOW);
    endfunction : dig
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h65f1));
        cyc(10); rst_n <= 1'b1; active <= 1'b1; gap <= 8'(10 + $urandom % 30);
        cyc(RC + 5); note(32'(mcu_rst_out), 32'h1);
        ahb(0, OFS_STATE, 0); note(rd, 32'h0000_0004);
        ahb(0, OFS_STATUS, 0); note(rd, 32'h0000_000C);
        ahb(1, OFS_MASK, 32'h0000_0004); cyc(1); note(32'(irq), 32'h1);
        ahb(1, OFS_STATUS, 32'h0000_000C); cyc(1); note(32'(irq), 32'h0);
        ahb(0, 8'h0C, 0); note(rd, 32'h0);
        cyc(400); note(32'(wd_fault_oe_n), 32'h1);
        $display("registers and service done");
        for (int i = 0; i < 8; i++) begin
            active <= 1'b0; timeout_strap_a <= dig(i % 3); timeout_strap_b <= dig(i / 3);
            cyc(4); active <= 1'b1; cyc(2); active <= 1'b0; cyc(3);
            note(32'(wd_fault_oe_n), 32'h1); n = 3;
            while (wd_fault_oe_n && n < 7000) begin cyc(1); n++; end
            note(32'(n >= (WB << i) && n <= (WB << i) + 8), 32'h1);
            cyc(2); note(32'(mcu_rst_out), 32'h0);
            cyc(RC + 4); note(32'(mcu_rst_out), 32'h1);
            note(32'(wd_fault_oe_n), 32'h0);
        end
        $display("timeouts done");
        timeout_strap_a <= STRAP_HIGH; timeout_strap_b <= STRAP_HIGH;
        cyc(4); active <= 1'b1; cyc(2); active <= 1'b0; cyc(300);
        note(32'(wd_fault_oe_n), 32'h1);
        ahb(0, OFS_STATE, 0); note(rd, 32'h0000_008C);
        supply_low <= 1'b1; cyc(40); note(32'(mcu_rst_out), 32'h0);
        note(32'(mcu_rst_oe_n), 32'h0);
        supply_low <= 1'b0; n = 0;
        while (!mcu_rst_out && n < 200) begin cyc(1); n++; end
        note(32'(n >= RC && n <= RC + 6), 32'h1);
        $display("disable and supply done");
        for (int s = 0; s < 2; s++) begin
            speed_sel <= s[0]; cyc(8); n = 0;
            repeat (40) begin b = mcu_clk_out; @(negedge core_clk); n += int'(mcu_clk_out !== b); end
            note(32'(n), s ? 32'd40 : 32'd20);
            cyc(1);
        end
        $display("speed done");
        cyc(2);
        finish_test();
    end
endmodule : tb_mcu_clock_supervisor_watchdog
